// file: alm_lane_mapper_regs.svh
// Register map, field layout and reset constants of the lane output mapper
`ifndef ALM_LANE_MAPPER_REGS_SVH
`define ALM_LANE_MAPPER_REGS_SVH
// ============================================================
// Overview of operation
// RULE1: Upper codes 0,2,4,6 route channels 8..5.
// RULE2: Odd upper codes send high byte, two-lane only.
// RULE3: Top code bit set powers the lane down.
// RULE4: Reset maps channel k to primary lane k.
// RULE5: One-lane default leaves secondary lanes without data.
// RULE6: Two-lane default splits channel k over pair k.
// RULE7: Select nibbles live at indexes 0x50 to 0x55.
// RULE8: Lower group codes pick channels 1..4 ascending.
// RULE9: Each channel group reaches only its own pairs.
// RULE10: Two-lane code in one-lane mode sends idle.
// ============================================================
// Widths of the data path
`define ALM_SAMPLE_W 14
`define ALM_BYTE_W 8
`define ALM_NUM_CH 8
`define ALM_NUM_LANES 16
`define ALM_SEL_W 4
`define ALM_UPPER_FIRST_LANE 8
`define ALM_FIFO_DEPTH 4
// ============================================================
// Bus geometry and register indexes (byte address is four times the index)
`define ALM_ADDR_W 12
`define ALM_IDX_W 10
`define ALM_IDX_SEL_FIRST 10'h050
`define ALM_IDX_SEL_LAST 10'h055
`define ALM_IDX_MODE 10'h056
`define ALM_IDX_STATUS 10'h057
`define ALM_FIELDS_PER_REG 3
`define ALM_RESP_OKAY 2'h0
`define ALM_RESP_SLVERR 2'h2
// ============================================================
// Field placement: entry (reg*3+nibble) holds a lane number, 8'h1F means no field
`define ALM_FIELD_LANE_MAP 144'h1F0E0F0C0D0A0B08091F0706050403020100
`define ALM_FIELD_ENTRY_W 8
`define ALM_FIELD_NONE_BIT 4
// Reset select codes in lane order, lane 0 in the low nibble
`define ALM_SEL_RESET 64'h1032547676543210
`define ALM_SEL_TOP_BIT 3
`define ALM_MODE_TWO_LANE_BIT 0
`define ALM_MODE_RESET 1'b0
// Status layout: lane power flags, then fifo level, then map-changed flag
`define ALM_STAT_LEVEL_LSB 16
`define ALM_STAT_TOUCHED_BIT 19
// Pattern driven on a lane whose code is illegal for one-lane mode
`define ALM_IDLE_WORD 14'h2AAA
`endif

// file: alm_pkg.sv
// Shared data carriers of the lane output mapper
`include "alm_lane_mapper_regs.svh"
package alm_pkg;
    // One converter sample set, channel 1 at index 0
    typedef struct packed {
        logic [`ALM_NUM_CH-1:0][`ALM_SAMPLE_W-1:0] ch;
    } alm_sample_s;
    // Words and power state of all lanes; lane 2k is primary of pair k+1
    typedef struct packed {
        logic [`ALM_NUM_LANES-1:0][`ALM_SAMPLE_W-1:0] word;
        logic [`ALM_NUM_LANES-1:0] on;
    } alm_lanes_s;
    typedef logic [`ALM_SEL_W-1:0] alm_sel_t;
endpackage

// file: alm_lane_mapper.sv
// Channel-to-lane crossbar with sample fifo and AXI4-Lite configuration port
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "alm_lane_mapper_regs.svh"

// ============================================================
// Sample fifo
module alm_fifo
    import alm_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [PW:0] count_r, count_nxt;
    logic in_ready_r, in_ready_nxt, out_valid_r, out_valid_nxt;
    logic push, pop;

    // Flags are registered from the next count so both sides see flop outputs
    always_comb
    begin
        push = in_valid && in_ready_r;
        pop = out_valid_r && out_ready;
        wr_ptr_nxt = push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
        rd_ptr_nxt = pop ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
        count_nxt = (PW+1)'(count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
        in_ready_nxt = count_nxt != (PW+1)'(DEPTH);
        out_valid_nxt = count_nxt != '0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            in_ready_r <= 1'b0;
            out_valid_r <= 1'b0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            in_ready_r <= in_ready_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data = mem[rd_ptr_r];
    assign level = count_r;
endmodule

// ============================================================
// Lane mapper top
module alm_lane_mapper
    import alm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input alm_sample_s s_sample,
    input wire logic s_valid,
    output logic s_ready,
    output alm_lanes_s lane_out,
    output logic lane_valid,
    input wire logic lane_ready,
    input wire logic [`ALM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ALM_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int LW = $clog2(`ALM_FIFO_DEPTH) + 1;
    alm_sample_s fifo_data;
    logic fifo_valid, take;
    logic [LW-1:0] fifo_level;
    alm_sel_t [`ALM_NUM_LANES-1:0] sel_r, sel_nxt;
    logic two_lane_r, two_lane_nxt, touched_r, touched_nxt;
    logic [`ALM_NUM_LANES-1:0][`ALM_SAMPLE_W-1:0] map_word;
    logic [`ALM_NUM_LANES-1:0] map_on;
    alm_lanes_s lanes_r, lanes_nxt;
    logic out_valid_r, out_valid_nxt;
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, awready_r, awready_nxt;
    logic wready_r, wready_nxt, bvalid_r, bvalid_nxt, do_write;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [`ALM_IDX_W-1:0] aw_idx_r, aw_idx_nxt;
    logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt, rd_take;

    // ============================================================
    // Input buffering; a stalled serializer backs up into s_ready
    alm_fifo #(.WIDTH($bits(alm_sample_s)), .DEPTH(`ALM_FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_data(s_sample),
        .in_valid(s_valid),
        .in_ready(s_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(take),
        .level(fifo_level)
    );

    // ============================================================
    // Per-lane source selection
    for (genvar i = 0; i < `ALM_NUM_LANES; i++)
    begin : g_lane
        logic [2:0] chi;
        logic [`ALM_SAMPLE_W-1:0] src;
        // Upper group counts down from channel 8, so its index is mirrored
        always_comb
        begin
            if (i >= `ALM_UPPER_FIRST_LANE)
                chi = ~{1'b0, sel_r[i][2:1]}; // RULE1 RULE9
            else
                chi = {1'b0, sel_r[i][2:1]}; // RULE8 RULE9
            src = fifo_data.ch[chi];
            map_on[i] = !sel_r[i][`ALM_SEL_TOP_BIT]; // RULE3
            if (sel_r[i][`ALM_SEL_TOP_BIT])
                map_word[i] = '0; // RULE3
            else if (!two_lane_r && sel_r[i][0])
                map_word[i] = `ALM_IDLE_WORD; // RULE10 RULE5
            else if (two_lane_r && sel_r[i][0])
                map_word[i] = {{`ALM_BYTE_W{1'b0}}, src[`ALM_SAMPLE_W-1:`ALM_BYTE_W]}; // RULE2
            else if (two_lane_r)
                map_word[i] = {{(`ALM_SAMPLE_W-`ALM_BYTE_W){1'b0}},
                    src[`ALM_BYTE_W-1:0]}; // RULE1 RULE6
            else
                map_word[i] = src; // RULE1 RULE4
        end
    end

    // ============================================================
    // Output stage; a new sample set loads once the old one is taken
    always_comb
    begin
        take = fifo_valid && (!out_valid_r || lane_ready);
        out_valid_nxt = take || (out_valid_r && !lane_ready);
        lanes_nxt = lanes_r;
        if (take)
        begin
            lanes_nxt.word = map_word;
            lanes_nxt.on = map_on;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            out_valid_r <= 1'b0;
            lanes_r <= '0;
        end
        else
        begin
            out_valid_r <= out_valid_nxt;
            lanes_r <= lanes_nxt;
        end
    end

    // ============================================================
    // Write channel: address and data latch in either order
    always_comb
    begin
        do_write = aw_held_r && w_held_r && !bvalid_r;
        aw_held_nxt = aw_held_r ? !do_write : (s_axi_awvalid && awready_r);
        w_held_nxt = w_held_r ? !do_write : (s_axi_wvalid && wready_r);
        awready_nxt = !aw_held_nxt;
        wready_nxt = !w_held_nxt;
        aw_idx_nxt = (s_axi_awvalid && awready_r) ? s_axi_awaddr[`ALM_ADDR_W-1:2] : aw_idx_r;
        w_data_nxt = (s_axi_wvalid && wready_r) ? s_axi_wdata : w_data_r;
        w_strb_nxt = (s_axi_wvalid && wready_r) ? s_axi_wstrb : w_strb_r;
        bvalid_nxt = do_write || (bvalid_r && !s_axi_bready);
        bresp_nxt = bresp_r;
        if (do_write)
            bresp_nxt = (aw_idx_r >= `ALM_IDX_SEL_FIRST && aw_idx_r <= `ALM_IDX_STATUS)
                ? `ALM_RESP_OKAY : `ALM_RESP_SLVERR;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_idx_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= `ALM_RESP_OKAY;
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            aw_idx_r <= aw_idx_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // ============================================================
    // Configuration: three nibble fields per select register, two in 0x52 and 0x55
    always_comb
    begin
        int e;
        logic [`ALM_FIELD_ENTRY_W-1:0] ln;
        e = 0;
        ln = '0;
        sel_nxt = sel_r;
        two_lane_nxt = two_lane_r;
        touched_nxt = touched_r;
        if (do_write && aw_idx_r >= `ALM_IDX_SEL_FIRST && aw_idx_r <= `ALM_IDX_SEL_LAST)
        begin
            touched_nxt = 1'b1;
            for (int n = 0; n < `ALM_FIELDS_PER_REG; n++)
            begin
                e = int'(aw_idx_r - `ALM_IDX_SEL_FIRST) * `ALM_FIELDS_PER_REG + n;
                ln = `ALM_FIELD_ENTRY_W'(`ALM_FIELD_LANE_MAP >> (e * `ALM_FIELD_ENTRY_W));
                if (!ln[`ALM_FIELD_NONE_BIT] && w_strb_r[n/2])
                    sel_nxt[ln[3:0]] = w_data_r[n*`ALM_SEL_W +: `ALM_SEL_W]; // RULE7
            end
        end
        if (do_write && aw_idx_r == `ALM_IDX_MODE && w_strb_r[0])
        begin
            two_lane_nxt = w_data_r[`ALM_MODE_TWO_LANE_BIT];
            touched_nxt = 1'b1;
        end
    end

    // Reset codes give channel k the primary lane of pair k
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sel_r <= `ALM_SEL_RESET; // RULE4 RULE6
            two_lane_r <= `ALM_MODE_RESET;
            touched_r <= 1'b0;
        end
        else
        begin
            sel_r <= sel_nxt;
            two_lane_r <= two_lane_nxt;
            touched_r <= touched_nxt;
        end
    end

    // ============================================================
    // Read channel: answer one cycle after the address is taken
    always_comb
    begin
        int e;
        logic [`ALM_FIELD_ENTRY_W-1:0] ln;
        logic [`ALM_IDX_W-1:0] ridx;
        e = 0;
        ln = '0;
        ridx = s_axi_araddr[`ALM_ADDR_W-1:2];
        rd_take = s_axi_arvalid && arready_r;
        rvalid_nxt = rd_take || (rvalid_r && !s_axi_rready);
        arready_nxt = !rvalid_nxt;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rd_take)
        begin
            rdata_nxt = '0;
            rresp_nxt = `ALM_RESP_OKAY;
            if (ridx >= `ALM_IDX_SEL_FIRST && ridx <= `ALM_IDX_SEL_LAST)
            begin
                for (int n = 0; n < `ALM_FIELDS_PER_REG; n++)
                begin
                    e = int'(ridx - `ALM_IDX_SEL_FIRST) * `ALM_FIELDS_PER_REG + n;
                    ln = `ALM_FIELD_ENTRY_W'(`ALM_FIELD_LANE_MAP >> (e * `ALM_FIELD_ENTRY_W));
                    if (!ln[`ALM_FIELD_NONE_BIT])
                        rdata_nxt[n*`ALM_SEL_W +: `ALM_SEL_W] = sel_r[ln[3:0]];
                end
            end
            else if (ridx == `ALM_IDX_MODE)
                rdata_nxt[`ALM_MODE_TWO_LANE_BIT] = two_lane_r;
            else if (ridx == `ALM_IDX_STATUS)
            begin
                rdata_nxt[`ALM_NUM_LANES-1:0] = lanes_r.on;
                rdata_nxt[`ALM_STAT_LEVEL_LSB +: LW] = fifo_level;
                rdata_nxt[`ALM_STAT_TOUCHED_BIT] = touched_r;
            end
            else
                rresp_nxt = `ALM_RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `ALM_RESP_OKAY;
        end
        else
        begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign lane_out = lanes_r;
    assign lane_valid = out_valid_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ============================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_load;
        take;
    endsequence
    sequence s_default_load;
        !touched_r && take;
    endsequence
    sequence s_sel51_full;
        do_write && aw_idx_r == `ALM_IDX_SEL_FIRST + 10'h001 && w_strb_r[0];
    endsequence

    AST_DEFAULT_ONE_LANE: assert property (s_default_load |=> lanes_r.word[6] == $past(fifo_data.ch[3]) && lanes_r.word[14] == $past(fifo_data.ch[7])) else $error("default primary lane mismatch"); // RULE4
    AST_ONE_LANE_SECONDARY_IDLE: assert property (s_default_load ##0 !two_lane_r |=> lanes_r.word[1] == `ALM_IDLE_WORD && lanes_r.word[15] == `ALM_IDLE_WORD) else $error("secondary lane carries data"); // RULE5
    AST_TWO_LANE_SPLIT: assert property (s_load ##0 two_lane_r && sel_r[8] == 4'h6 && sel_r[9] == 4'h7 |=> lanes_r.word[8][7:0] == $past(fifo_data.ch[4][7:0]) && lanes_r.word[9][5:0] == $past(fifo_data.ch[4][13:8])) else $error("two-lane split wrong"); // RULE6
    AST_CFG_WRITE: assert property (s_sel51_full |=> sel_r[3] == $past(w_data_r[3:0]) && sel_r[4] == $past(w_data_r[7:4])) else $error("select field not stored"); // RULE7
    AST_WRITE_RESP: assert property (s_axi_awvalid && awready_r && s_axi_wvalid && wready_r |-> ##[1:2] bvalid_r) else $error("write response late");

    for (genvar i = 0; i < `ALM_NUM_LANES; i++)
    begin : g_chk
        AST_POWER_DOWN: assert property (s_load ##0 sel_r[i][3] |=> !lanes_r.on[i] && lanes_r.word[i] == '0) else $error("lane not powered down"); // RULE3
        AST_ILLEGAL_IDLE: assert property (s_load ##0 !two_lane_r && sel_r[i][3:0] == 4'h3 |=> lanes_r.word[i] == `ALM_IDLE_WORD) else $error("idle pattern missing"); // RULE10
        if (i >= `ALM_UPPER_FIRST_LANE)
        begin : g_up
            AST_UPPER_LOW: assert property (s_load ##0 two_lane_r && sel_r[i] == 4'h2 |=> lanes_r.word[i] == {6'h00, $past(fifo_data.ch[6][7:0])}) else $error("upper low byte wrong"); // RULE1
            AST_UPPER_HIGH: assert property (s_load ##0 two_lane_r && sel_r[i] == 4'h7 |=> lanes_r.word[i] == {8'h00, $past(fifo_data.ch[4][13:8])}) else $error("upper high byte wrong"); // RULE2
        end
        else
        begin : g_lo
            AST_LOWER_PICK: assert property (s_load ##0 !two_lane_r && sel_r[i] == 4'h4 |=> lanes_r.word[i] == $past(fifo_data.ch[2])) else $error("lower pick wrong"); // RULE8 RULE9
        end
    end
endmodule

// file: alm_rx_model.sv
// Serializer-side receiver model that captures mapped lane sets
`timescale 1ns/1ps
module alm_rx_model
    import alm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input alm_lanes_s lane_out,
    input wire logic lane_valid,
    output logic lane_ready,
    input wire logic hold,
    input wire logic slow
);
    alm_lanes_s got[$];
    logic tick_r;

    // ============================================================
    // Capture on handshake; slow mode refuses every other cycle
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            lane_ready <= 1'b0;
            tick_r <= 1'b0;
        end
        else
        begin
            if (lane_valid && lane_ready)
                got.push_back(lane_out);
            tick_r <= ~tick_r;
            lane_ready <= !hold && !(slow && tick_r);
        end
    end
endmodule

// file: test_alm_lane_mapper.sv
// Self-checking testbench of the lane output mapper
`timescale 1ns/1ps
`include "alm_lane_mapper_regs.svh"
module test_alm_lane_mapper
    import alm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    alm_sample_s s_sample = '0;
    logic s_valid = 1'b0;
    logic s_ready;
    alm_lanes_s lane_out;
    logic lane_valid;
    logic lane_ready;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic [`ALM_ADDR_W-1:0] s_axi_awaddr = '0;
    logic [`ALM_ADDR_W-1:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready;
    logic s_axi_wready;
    logic s_axi_bvalid;
    logic s_axi_arready;
    logic s_axi_rvalid;
    int err_count = 0;
    int num_checks = 0;
    alm_sel_t sel [16];
    logic two = 1'b0;
    alm_lanes_s exp_q[$];

    alm_lane_mapper i_dut (.sys_clk, .rstn, .s_sample, .s_valid, .s_ready, .lane_out,
        .lane_valid, .lane_ready, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    alm_rx_model i_rx (.sys_clk, .rstn, .lane_out, .lane_valid, .lane_ready, .hold, .slow);

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    // ============================================================
    // Reporting and comparison
    task automatic bad(input string m);
        err_count++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
            bad($sformatf("word %h expected %h", g, e));
    endtask
    task automatic cmp_lanes(input alm_lanes_s g, input alm_lanes_s e);
        num_checks++;
        if (g !== e)
            bad($sformatf("lanes %h expected %h", g, e));
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ============================================================
    // Expected lane set from the select codes and mode held here
    function automatic alm_lanes_s exp_map(input alm_sample_s s, input logic tw);
        alm_lanes_s e;
        alm_sel_t c;
        logic [`ALM_SAMPLE_W-1:0] w;
        for (int l = 0; l < 16; l++)
        begin
            c = sel[l];
            w = (l < 8) ? s.ch[{1'b0, c[2:1]}] : s.ch[3'd7 - {1'b0, c[2:1]}];
            e.on[l] = !c[3];
            if (c[3])
                e.word[l] = '0;
            else if (!tw)
                e.word[l] = c[0] ? `ALM_IDLE_WORD : w;
            else
                e.word[l] = c[0] ? {8'h00, w[13:8]} : {6'h00, w[7:0]};
        end
        return e;
    endfunction
    function automatic alm_sample_s mk(input int v);
        alm_sample_s s;
        for (int k = 0; k < 8; k++)
            s.ch[k] = 14'(v * 613 + k * 1847 + 3);
        return s;
    endfunction

    // ============================================================
    // Register bus master: valid held until its own ready
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [2:0] dn;
        int n;
        dn = 3'b000;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (dn != 3'b111 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
            if (!dn[0] && s_axi_awready)
            begin
                dn[0] = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!dn[1] && s_axi_wready)
            begin
                dn[1] = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid)
            begin
                dn[2] = 1'b1;
                s_axi_bready <= 1'b0;
                cmp32({30'h0, s_axi_bresp}, {30'h0, er});
            end
        end
        if (n >= 100)
            bad("write hang");
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 100);
        if (n >= 100)
            bad("read hang");
        s_axi_rready <= 1'b0;
        cmp32(s_axi_rdata, ed);
        cmp32({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // ============================================================
    // Sample source and lane collection
    task automatic push(input alm_sample_s s);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_sample <= s;
        s_valid <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (!s_ready && n < 100);
        if (n >= 100)
            bad("push hang");
        s_valid <= 1'b0;
        exp_q.push_back(exp_map(s, two));
    endtask
    task automatic pull();
        int n;
        n = 0;
        while (i_rx.got.size() == 0 && n < 200)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200)
            bad("no lane set");
        else
            cmp_lanes(i_rx.got.pop_front(), exp_q.pop_front());
    endtask
    task automatic set_sel();
        axw(12'h140, {20'h0, sel[2], sel[1], sel[0]}, `ALM_RESP_OKAY);
        axw(12'h144, {20'h0, sel[5], sel[4], sel[3]}, `ALM_RESP_OKAY);
        axw(12'h14C, {20'h0, sel[11], sel[8], sel[9]}, `ALM_RESP_OKAY);
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        // Primary of pair j+1 carries channel j+1, secondary its high byte
        for (int j = 0; j < 8; j++)
        begin
            sel[2*j] = 4'((j < 4) ? 2 * j : 2 * (7 - j));
            sel[2*j+1] = sel[2*j] | 4'h1;
        end
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        axr(12'h158, 32'h00000000, `ALM_RESP_OKAY);
        axr(12'h140, 32'h00000210, `ALM_RESP_OKAY);
        // Receiver stalls: one set in the output stage, four in the fifo
        hold <= 1'b1;
        for (int i = 0; i < 5; i++)
            push(mk(i));
        repeat (3) @(posedge sys_clk);
        cmp32({31'h0, s_ready}, 32'h0);
        axr(12'h15C, 32'h0004FFFF, `ALM_RESP_OKAY);
        hold <= 1'b0;
        for (int i = 0; i < 5; i++)
            pull();
        axr(12'h200, 32'h0, `ALM_RESP_SLVERR);
        axw(12'h204, 32'h7, `ALM_RESP_SLVERR);
        // Only the second byte lane enabled: fields 0 and 1 must keep their codes
        s_axi_wstrb <= 4'h2;
        axw(12'h140, {20'h0, sel[2], 4'hF, 4'hF}, `ALM_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axr(12'h140, {20'h0, sel[2], sel[1], sel[0]}, `ALM_RESP_OKAY);
        // Two-lane default split, slow receiver, back to back sets
        axw(12'h158, 32'h1, `ALM_RESP_OKAY);
        two = 1'b1;
        slow <= 1'b1;
        for (int i = 0; i < 3; i++)
            push(mk(20 + i));
        for (int i = 0; i < 3; i++)
            pull();
        slow <= 1'b0;
        // Every code on one lower and one upper lane, in both modes
        for (int m = 0; m < 2; m++)
        begin
            two = (m == 1);
            axw(12'h158, {31'h0, two}, `ALM_RESP_OKAY);
            for (int c = 0; c < 16; c++)
            begin
                sel[0] = 4'(c);
                sel[8] = 4'(c);
                set_sel();
                axr(12'h14C, {20'h0, sel[11], sel[8], sel[9]}, `ALM_RESP_OKAY);
                push(mk(40 + c));
                pull();
            end
        end
        conclude();
    end

    // Watchdog sized well beyond the expected run
    initial
    begin
        #100000;
        bad("timeout");
        conclude();
    end
endmodule
